// ==== verilog/rcc_pkg.sv ====
package rcc_pkg;

	localparam int RCC_NUM_CH = 4;
	localparam int RCC_VSEL_W = 6;
	localparam int RCC_VSEL4_W = 8;

	// Channel positions inside per-channel vectors
	localparam int RCC_IDX_CH3 = 0;
	localparam int RCC_IDX_CH4 = 1;
	localparam int RCC_IDX_CH5 = 2;
	localparam int RCC_IDX_CH6 = 3;

	localparam logic [7:0] RCC_ADDR_CH3_VSEL = 8'h30;
	localparam logic [7:0] RCC_ADDR_CH3_CTRL = 8'h32;
	localparam logic [7:0] RCC_ADDR_CH4_VSEL = 8'h40;
	localparam logic [7:0] RCC_ADDR_CH4_CTRL = 8'h41;
	localparam logic [7:0] RCC_ADDR_CH5_VSEL = 8'h50;
	localparam logic [7:0] RCC_ADDR_CH5_CTRL = 8'h51;
	localparam logic [7:0] RCC_ADDR_CH6_VSEL = 8'h60;
	localparam logic [7:0] RCC_ADDR_CH6_CTRL = 8'h61;
	localparam logic [7:0] RCC_ADDR_IRQ_STATUS = 8'h3e;
	localparam logic [7:0] RCC_ADDR_IRQ_MASK = 8'h3f;

	// Control register field positions
	localparam int RCC_CTRL_ENABLE_BIT = 7;
	localparam int RCC_CTRL_OPTION_BIT = 2;
	localparam int RCC_CTRL_UNMASK_BIT = 1;
	localparam int RCC_CTRL_PGOOD_BIT = 0;

	// Status layout: fault events low nibble, power-good loss high nibble
	localparam int RCC_STAT_FAULT_LSB = 0;
	localparam int RCC_STAT_PGLOSS_LSB = 4;

	localparam logic [5:0] RCC_VSEL_RST = 6'h00;
	localparam logic [7:0] RCC_VSEL4_RST = 8'h00;
	localparam logic RCC_ENABLE_RST = 1'h0;
	localparam logic RCC_PHASE_RST = 1'h0;
	localparam logic RCC_UNMASK_RST = 1'h0;
	localparam logic RCC_DISCHARGE_RST = 1'h0;
	localparam logic [7:0] RCC_IRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] RCC_IRQ_MASK_RST = 8'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcc_bus_req_type;

	typedef struct packed {
		logic [5:0] voltage_select_ch3;
		logic [7:0] voltage_select_ch4;
		logic [5:0] voltage_select_ch5;
		logic [5:0] voltage_select_ch6;
		logic [3:0] enable;
		logic phase_ch3;
		logic [1:0] discharge;
	} rcc_reg_ctrl_type;

endpackage

// ==== verilog/rcc_regs.sv ====
`timescale 1ns/10ps
module rcc_regs
	import rcc_pkg::*;
(
	input wire logic i_mclk, // 200 MHz clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire rcc_bus_req_type i_bus, // Register bus request
	input wire logic [3:0] i_power_good, // Power-good pins, ch3..ch6
	input wire logic [3:0] i_fault, // Fault pins, ch3..ch6
	output logic [7:0] o_rdata, // Read data, cycle after read
	output rcc_reg_ctrl_type o_reg_ctrl, // Regulator controls
	output logic [3:0] o_fault_irq_req, // Per-channel fault requests
	output logic o_irq // Interrupt, active high level
);

	logic [3:0] pg_meta;
	logic [3:0] pg_sync;
	logic [3:0] pg_prev;
	logic [3:0] fault_meta;
	logic [3:0] fault_sync;

	logic [5:0] vsel3;
	logic [7:0] vsel4;
	logic [5:0] vsel5;
	logic [5:0] vsel6;
	logic [3:0] enable;
	logic phase3;
	logic unmask3;
	logic unmask5;
	logic unmask6;
	logic discharge_enable5;
	logic discharge_enable6;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;

	// Pins come from the analogue domain
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			pg_meta <= 4'h0;
			pg_sync <= 4'h0;
			fault_meta <= 4'h0;
			fault_sync <= 4'h0;
		end
		else
		begin
			pg_meta <= i_power_good;
			pg_sync <= pg_meta;
			fault_meta <= i_fault;
			fault_sync <= fault_meta;
		end
	end

	// Address decode
	wire hit_vsel3 = i_bus.addr == RCC_ADDR_CH3_VSEL;
	wire hit_ctrl3 = i_bus.addr == RCC_ADDR_CH3_CTRL;
	wire hit_vsel4 = i_bus.addr == RCC_ADDR_CH4_VSEL;
	wire hit_ctrl4 = i_bus.addr == RCC_ADDR_CH4_CTRL;
	wire hit_vsel5 = i_bus.addr == RCC_ADDR_CH5_VSEL;
	wire hit_ctrl5 = i_bus.addr == RCC_ADDR_CH5_CTRL;
	wire hit_vsel6 = i_bus.addr == RCC_ADDR_CH6_VSEL;
	wire hit_ctrl6 = i_bus.addr == RCC_ADDR_CH6_CTRL;
	wire hit_status = i_bus.addr == RCC_ADDR_IRQ_STATUS;
	wire hit_mask = i_bus.addr == RCC_ADDR_IRQ_MASK;

	wire wr_vsel3 = i_bus.wr && hit_vsel3;
	wire wr_ctrl3 = i_bus.wr && hit_ctrl3;
	wire wr_vsel4 = i_bus.wr && hit_vsel4;
	wire wr_ctrl4 = i_bus.wr && hit_ctrl4;
	wire wr_vsel5 = i_bus.wr && hit_vsel5;
	wire wr_ctrl5 = i_bus.wr && hit_ctrl5;
	wire wr_vsel6 = i_bus.wr && hit_vsel6;
	wire wr_ctrl6 = i_bus.wr && hit_ctrl6;
	wire wr_status = i_bus.wr && hit_status;
	wire wr_mask = i_bus.wr && hit_mask;

	wire wbit_enable = i_bus.wdata[RCC_CTRL_ENABLE_BIT];
	wire wbit_option = i_bus.wdata[RCC_CTRL_OPTION_BIT];
	wire wbit_unmask = i_bus.wdata[RCC_CTRL_UNMASK_BIT];

	wire [5:0] next_vsel3 = wr_vsel3 ? i_bus.wdata[RCC_VSEL_W-1:0] : vsel3;
	wire [7:0] next_vsel4 = wr_vsel4 ? i_bus.wdata[RCC_VSEL4_W-1:0] : vsel4;
	wire [5:0] next_vsel5 = wr_vsel5 ? i_bus.wdata[RCC_VSEL_W-1:0] : vsel5;
	wire [5:0] next_vsel6 = wr_vsel6 ? i_bus.wdata[RCC_VSEL_W-1:0] : vsel6;

	wire [3:0] wr_ctrl_vec = {wr_ctrl6, wr_ctrl5, wr_ctrl4, wr_ctrl3};
	wire [3:0] next_enable = (enable & ~wr_ctrl_vec) | ({4{wbit_enable}} & wr_ctrl_vec);

	// phase select, one means 180 degrees
	// zero keeps the converter in phase
	wire next_phase3 = wr_ctrl3 ? wbit_option : phase3;

	// channel four has no unmask or option bit
	// unmask bits for channels three, five, six
	wire next_unmask3 = wr_ctrl3 ? wbit_unmask : unmask3;
	wire next_unmask5 = wr_ctrl5 ? wbit_unmask : unmask5;
	wire next_unmask6 = wr_ctrl6 ? wbit_unmask : unmask6;

	wire next_discharge_enable5 = wr_ctrl5 ? wbit_option : discharge_enable5;
	wire next_discharge_enable6 = wr_ctrl6 ? wbit_option : discharge_enable6;

	// discharge only while the channel is off
	wire [1:0] next_discharge = {
		next_discharge_enable6 & ~next_enable[RCC_IDX_CH6],
		next_discharge_enable5 & ~next_enable[RCC_IDX_CH5]
	};

	// Channel four lacks an unmask bit, so its faults always pass
	wire [3:0] fault_gate = {unmask6, unmask5, 1'h1, unmask3};

	// fault request is fault AND unmask
	wire [3:0] fault_req = fault_sync & fault_gate;

	// Event sources for the sticky status
	wire [7:0] irq_set = {pg_prev & ~pg_sync, fault_req};
	wire [7:0] irq_clr = wr_status ? i_bus.wdata : 8'h00;
	logic [7:0] next_irq_status;

	// Set wins over a same-cycle clear so no event is lost
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_status
			assign next_irq_status[gi] = irq_set[gi] | (irq_status[gi] & ~irq_clr[gi]);
		end
	endgenerate

	wire [7:0] next_irq_mask = wr_mask ? i_bus.wdata : irq_mask;

	// reserved bits read back as zero
	wire [7:0] rd_ctrl3 = {enable[RCC_IDX_CH3], 4'h0, phase3, unmask3, pg_sync[RCC_IDX_CH3]};
	wire [7:0] rd_ctrl4 = {enable[RCC_IDX_CH4], 6'h00, pg_sync[RCC_IDX_CH4]};
	wire [7:0] rd_ctrl5 = {enable[RCC_IDX_CH5], 4'h0, discharge_enable5, unmask5,
		pg_sync[RCC_IDX_CH5]};
	wire [7:0] rd_ctrl6 = {enable[RCC_IDX_CH6], 4'h0, discharge_enable6, unmask6,
		pg_sync[RCC_IDX_CH6]};

	// Unmapped addresses fall through to zero
	wire [7:0] rd_value =
		({8{hit_vsel3}} & {2'h0, vsel3}) |
		({8{hit_ctrl3}} & rd_ctrl3) |
		({8{hit_vsel4}} & vsel4) |
		({8{hit_ctrl4}} & rd_ctrl4) |
		({8{hit_vsel5}} & {2'h0, vsel5}) |
		({8{hit_ctrl5}} & rd_ctrl5) |
		({8{hit_vsel6}} & {2'h0, vsel6}) |
		({8{hit_ctrl6}} & rd_ctrl6) |
		({8{hit_status}} & irq_status) |
		({8{hit_mask}} & irq_mask);

	wire [7:0] next_rdata = i_bus.rd ? rd_value : 8'h00;

	rcc_reg_ctrl_type next_reg_ctrl;
	assign next_reg_ctrl.voltage_select_ch3 = next_vsel3;
	assign next_reg_ctrl.voltage_select_ch4 = next_vsel4;
	assign next_reg_ctrl.voltage_select_ch5 = next_vsel5;
	assign next_reg_ctrl.voltage_select_ch6 = next_vsel6;
	assign next_reg_ctrl.enable = next_enable;
	assign next_reg_ctrl.phase_ch3 = next_phase3;
	assign next_reg_ctrl.discharge = next_discharge;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			vsel3 <= RCC_VSEL_RST;
		end
		else
		begin
			vsel3 <= next_vsel3;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			vsel4 <= RCC_VSEL4_RST;
		end
		else
		begin
			vsel4 <= next_vsel4;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			vsel5 <= RCC_VSEL_RST;
		end
		else
		begin
			vsel5 <= next_vsel5;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			vsel6 <= RCC_VSEL_RST;
		end
		else
		begin
			vsel6 <= next_vsel6;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			enable <= {4{RCC_ENABLE_RST}};
		end
		else
		begin
			enable <= next_enable;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			phase3 <= RCC_PHASE_RST;
		end
		else
		begin
			phase3 <= next_phase3;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			unmask3 <= RCC_UNMASK_RST;
			unmask5 <= RCC_UNMASK_RST;
			unmask6 <= RCC_UNMASK_RST;
		end
		else
		begin
			unmask3 <= next_unmask3;
			unmask5 <= next_unmask5;
			unmask6 <= next_unmask6;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			discharge_enable5 <= RCC_DISCHARGE_RST;
			discharge_enable6 <= RCC_DISCHARGE_RST;
		end
		else
		begin
			discharge_enable5 <= next_discharge_enable5;
			discharge_enable6 <= next_discharge_enable6;
		end
	end

	// History starts low, so no false power-good loss after reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			pg_prev <= 4'h0;
		end
		else
		begin
			pg_prev <= pg_sync;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			irq_status <= RCC_IRQ_STATUS_RST;
		end
		else
		begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			irq_mask <= RCC_IRQ_MASK_RST;
		end
		else
		begin
			irq_mask <= next_irq_mask;
		end
	end

	// Outputs are flops so the analogue side never sees decode glitches
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_reg_ctrl <= '0;
		end
		else
		begin
			o_reg_ctrl <= next_reg_ctrl;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_rdata <= 8'h00;
		end
		else
		begin
			o_rdata <= next_rdata;
		end
	end

	// Interrupt built from next values to save a cycle of latency
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_fault_irq_req <= 4'h0;
			o_irq <= 1'h0;
		end
		else
		begin
			o_fault_irq_req <= fault_req;
			o_irq <= |(next_irq_status & next_irq_mask);
		end
	end

endmodule

// ==== verif/rcc_properties.sv ====
`timescale 1ns/10ps
module rcc_properties
	import rcc_pkg::*;
(
	input wire logic i_mclk, // Clock
	input wire logic i_rst_n, // Reset, active low
	input wire rcc_bus_req_type i_bus, // Bus request
	input wire logic [3:0] i_power_good, // Power-good pins
	input wire logic [3:0] i_fault, // Fault pins
	input wire logic [7:0] o_rdata, // Read data
	input wire rcc_reg_ctrl_type o_reg_ctrl, // Controls
	input wire logic [3:0] o_fault_irq_req, // Fault requests
	input wire logic o_irq // Interrupt
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	wire wr_c3 = i_bus.wr && i_bus.addr == RCC_ADDR_CH3_CTRL;
	wire wr_c5 = i_bus.wr && i_bus.addr == RCC_ADDR_CH5_CTRL;
	wire wr_v4 = i_bus.wr && i_bus.addr == RCC_ADDR_CH4_VSEL;
	// Pins held long enough to pass the synchronisers
	sequence pg_settled;
		(i_rst_n && $stable(i_power_good[1]))[*4];
	endsequence
	sequence fault_settled;
		(i_rst_n && $stable(i_fault[1]))[*4];
	endsequence
	rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
		else $error("read data not idle");
	ch3_enable_a: assert property (wr_c3 |=> o_reg_ctrl.enable[0] == $past(i_bus.wdata[7]))
		else $error("enable not taken");
	phase_sel_a: assert property (wr_c3 |=> o_reg_ctrl.phase_ch3 == $past(i_bus.wdata[2]))
		else $error("phase not taken");
	vsel_wide_a: assert property (wr_v4 |=> o_reg_ctrl.voltage_select_ch4 == $past(i_bus.wdata))
		else $error("wide code not taken");
	vsel_rsvd_a: assert property (i_bus.rd && i_bus.addr == 8'h30 |=> o_rdata[7:6] == 2'h0)
		else $error("reserved code bits set");
	discharge_off_a: assert property (wr_c5 |=>
		o_reg_ctrl.discharge[0] == ($past(i_bus.wdata[2]) && !$past(i_bus.wdata[7])))
		else $error("discharge wrong");
	fault_pass_a: assert property (fault_settled |-> o_fault_irq_req[1] == i_fault[1])
		else $error("fault request wrong");
	pg_read_a: assert property (pg_settled ##0 (i_bus.rd && i_bus.addr == 8'h41) |=>
		o_rdata[6:0] == {6'h00, $past(i_power_good[1])})
		else $error("status read wrong");
	irq_mask_a: assert property (i_bus.wr && i_bus.addr == 8'h3f && i_bus.wdata == 8'h00 |=> !o_irq)
		else $error("masked interrupt high");
endmodule
bind rcc_regs rcc_properties u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(i_bus),
	.i_power_good(i_power_good), .i_fault(i_fault), .o_rdata(o_rdata), .o_reg_ctrl(o_reg_ctrl),
	.o_fault_irq_req(o_fault_irq_req), .o_irq(o_irq));

// ==== verif/rcc_analog_model.sv ====
`timescale 1ns/10ps
module rcc_analog_model (
	input wire logic i_mclk, // Clock
	input wire logic [3:0] i_enable, // Channel enables
	input wire logic [3:0] i_fault_cmd, // Injected faults
	output logic [3:0] o_power_good, // Power-good pins
	output logic [3:0] o_fault // Fault pins
);
	logic [7:0] ramp = 8'h00;
	// Output settles two cycles after enable changes
	always_ff @(posedge i_mclk)
	begin
		ramp <= {ramp[3:0], i_enable};
	end
	assign o_power_good = ramp[7:4];
	assign o_fault = i_fault_cmd;
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import rcc_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	rcc_bus_req_type i_bus = '0;
	logic [3:0] fault_cmd = 4'h0;
	logic [3:0] pg;
	logic [3:0] fault;
	logic [7:0] o_rdata;
	rcc_reg_ctrl_type ctl;
	logic [3:0] req;
	logic o_irq;
	logic [7:0] regs [8] = '{8'h30, 8'h32, 8'h40, 8'h41, 8'h50, 8'h51, 8'h60, 8'h61};
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	initial
	begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	rcc_regs dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(i_bus), .i_power_good(pg),
		.i_fault(fault), .o_rdata(o_rdata), .o_reg_ctrl(ctl), .o_fault_irq_req(req), .o_irq(o_irq));
	rcc_analog_model ana (.i_mclk(i_mclk), .i_enable(ctl.enable), .i_fault_cmd(fault_cmd),
		.o_power_good(pg), .o_fault(fault));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_bus <= '{1'h1, 1'h0, a, d};
		@(posedge i_mclk);
		i_bus <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_bus <= '{1'h0, 1'h1, a, 8'h00};
		@(posedge i_mclk);
		i_bus <= '0;
		#1 check(o_rdata, exp);
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task complete_run;
		$display("tests %0d errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, run needs about 120 cycles
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			complete_run();
		end
	end
	initial
	begin
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(regs[i], 8'h00);
		rd(8'h31, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(regs[2 * i], (i == 1) ? 8'hff : 8'h3f);
			rd(regs[2 * i], (i == 1) ? 8'hff : 8'h3f);
		end
		check({2'h0, ctl.voltage_select_ch3}, 8'h3f);
		check(ctl.voltage_select_ch4, 8'hff);
		check({2'h0, ctl.voltage_select_ch5}, 8'h3f);
		check({2'h0, ctl.voltage_select_ch6}, 8'h3f);
		wr(RCC_ADDR_CH3_CTRL, 8'h87);
		wr(RCC_ADDR_CH4_CTRL, 8'h80);
		wr(RCC_ADDR_CH5_CTRL, 8'h04);
		wr(RCC_ADDR_CH6_CTRL, 8'h86);
		tick(6);
		check({ctl.enable, 1'h0, ctl.phase_ch3, ctl.discharge}, 8'hb5);
		rd(RCC_ADDR_CH3_CTRL, 8'h87);
		rd(RCC_ADDR_CH4_CTRL, 8'h81);
		rd(RCC_ADDR_CH5_CTRL, 8'h04);
		rd(RCC_ADDR_CH6_CTRL, 8'h87);
		wr(RCC_ADDR_CH3_CTRL, 8'h81);
		wr(RCC_ADDR_CH5_CTRL, 8'h84);
		#1 check({6'h00, ctl.phase_ch3, ctl.discharge[0]}, 8'h00);
		wr(RCC_ADDR_IRQ_MASK, 8'h0f);
		fault_cmd <= 4'hf;
		tick(6);
		check({req, 3'h0, o_irq}, 8'ha1);
		wr(RCC_ADDR_IRQ_MASK, 8'h00);
		#1 check({7'h00, o_irq}, 8'h00);
		wr(RCC_ADDR_IRQ_MASK, 8'h0f);
		@(posedge i_mclk);
		fault_cmd <= 4'h4;
		tick(6);
		wr(RCC_ADDR_IRQ_STATUS, 8'hff);
		tick(2);
		check({req, 3'h0, o_irq}, 8'h00);
		rd(RCC_ADDR_IRQ_STATUS, 8'h00);
		// Channel six off: power-good loss event
		wr(RCC_ADDR_CH6_CTRL, 8'h06);
		tick(8);
		check({6'h00, ctl.discharge}, 8'h02);
		check({req, 3'h0, o_irq}, 8'h00);
		rd(RCC_ADDR_CH6_CTRL, 8'h06);
		rd(RCC_ADDR_IRQ_STATUS, 8'h80);
		wr(RCC_ADDR_IRQ_MASK, 8'h80);
		#1 check({7'h00, o_irq}, 8'h01);
		wr(RCC_ADDR_IRQ_STATUS, 8'h80);
		#1 check({7'h00, o_irq}, 8'h00);
		complete_run();
	end
endmodule
